// ### src/dect_unit.sv
// one event counter with its own settings and state
// assumes source vectors and their previous values come from the same clock
`timescale 1ns/1ps
`default_nettype none
module dect_unit
	import dect_pkg::*;
#(
	parameter int CNT_W = 32
)
(
	input  wire logic                  i_mclk,
	input  wire logic                  i_reset_n,
	input  wire logic                  i_cfg_we,
	input  wire logic [DECT_SRC_W-1:0] i_increment_source_select,
	input  wire dect_act_t             i_increment_activation_mode,
	input  wire logic [CNT_W-1:0]      i_start_delay_count,
	input  wire logic [CNT_W-1:0]      i_end_duration_count,
	input  wire logic                  i_trig_we,
	input  wire logic [DECT_SRC_W-1:0] i_start_trigger_select,
	input  wire dect_act_t             i_start_trigger_activation_mode,
	input  wire logic                  i_clear_we,
	input  wire logic [DECT_SRC_W-1:0] i_clear_source_select,
	input  wire dect_act_t             i_clear_activation_mode,
	input  wire logic [DECT_NSRC-1:0]  i_src,
	input  wire logic [DECT_NSRC-1:0]  i_src_prev,
	output logic [CNT_W-1:0]           o_current_count,
	output logic [CNT_W-1:0]           o_count_captured_at_clear,
	output dect_state_t                o_counter_state,
	output logic                       o_begin_pulse,
	output logic                       o_finish_pulse
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed
	{
		logic [DECT_SRC_W-1:0] inc_sel;
		dect_act_t             inc_mode;
		logic [CNT_W-1:0]      delay;
		logic [CNT_W-1:0]      duration;
		logic [DECT_SRC_W-1:0] trig_sel;
		dect_act_t             trig_mode;
		logic [DECT_SRC_W-1:0] clr_sel;
		dect_act_t             clr_mode;
		logic [CNT_W-1:0]      count;
		logic [CNT_W-1:0]      captured;
		dect_state_t           state;
		logic                  begin_p;
		logic                  finish_p;
	} dect_unit_t;

	dect_unit_t s_r;
	dect_unit_t s_nxt;

	function automatic logic qualify(input logic [DECT_SRC_W-1:0] sel,
		input dect_act_t mode, input logic [DECT_NSRC-1:0] cur,
		input logic [DECT_NSRC-1:0] prev);
		logic c;
		logic p;
		logic q;
		c = cur[sel];
		p = prev[sel];
		q = 1'b0;
		if (sel == DECT_SRC_OFF || sel >= DECT_SRC_W'(DECT_NSRC))
			q = 1'b0;
		else if (DECT_PULSE_MASK[sel])
			q = c;
		else
		begin
			unique case (mode)
				DECT_ACT_LEVEL_LOW:  q = ~c;
				DECT_ACT_LEVEL_HIGH: q = c;
				DECT_ACT_FALLING:    q = p & ~c;
				DECT_ACT_RISING:     q = ~p & c;
				DECT_ACT_ANY_EDGE:   q = p ^ c;
				default:             q = 1'b0;
			endcase
		end
		return q;
	endfunction

	logic inc_hit;
	logic trig_hit;
	logic clr_hit;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.begin_p = 1'b0;
		s_nxt.finish_p = 1'b0;
		inc_hit = qualify(s_r.inc_sel, s_r.inc_mode, i_src, i_src_prev);
		trig_hit = qualify(s_r.trig_sel, s_r.trig_mode, i_src, i_src_prev);
		clr_hit = qualify(s_r.clr_sel, s_r.clr_mode, i_src, i_src_prev);
		if (s_r.state == DECT_ST_ACTIVE && inc_hit)
		begin
			if (s_r.count == {CNT_W{1'b1}})
				s_nxt.state = DECT_ST_OVERFLOW;
			else
			begin
				s_nxt.count = s_r.count + 1'b1;
				if (s_nxt.count == s_r.delay)
					s_nxt.begin_p = 1'b1;
				if (s_nxt.count == s_r.duration)
				begin
					s_nxt.finish_p = 1'b1;
					s_nxt.state = DECT_ST_COMPLETED;
				end
			end
		end
		if (trig_hit && (s_r.state == DECT_ST_TRIG_WAIT ||
			s_r.state == DECT_ST_COMPLETED))
		begin
			s_nxt.state = DECT_ST_ACTIVE;
			s_nxt.count = '0;
		end
		if (clr_hit && s_r.state != DECT_ST_IDLE)
		begin
			s_nxt.captured = s_r.count;
			s_nxt.count = '0;
			s_nxt.state = DECT_ST_ACTIVE;
			// the increment lost to the clear, so no event pulse
			s_nxt.begin_p = 1'b0;
			s_nxt.finish_p = 1'b0;
		end
		if (i_cfg_we)
		begin
			s_nxt.inc_sel = i_increment_source_select;
			s_nxt.inc_mode = i_increment_activation_mode;
			s_nxt.delay = i_start_delay_count;
			s_nxt.duration = i_end_duration_count;
		end
		if (i_clear_we)
		begin
			s_nxt.clr_sel = i_clear_source_select;
			s_nxt.clr_mode = i_clear_activation_mode;
			if (i_clear_source_select != DECT_SRC_OFF)
				s_nxt.trig_sel = DECT_SRC_OFF;
		end
		if (i_trig_we)
		begin
			s_nxt.trig_sel = i_start_trigger_select;
			s_nxt.trig_mode = i_start_trigger_activation_mode;
			if (i_start_trigger_select != DECT_SRC_OFF)
				s_nxt.clr_sel = DECT_SRC_OFF;
		end
		if (i_cfg_we || i_trig_we || i_clear_we)
		begin
			s_nxt.begin_p = 1'b0;
			s_nxt.finish_p = 1'b0;
			s_nxt.count = '0;
			s_nxt.state = (s_nxt.trig_sel != DECT_SRC_OFF) ?
				DECT_ST_TRIG_WAIT : DECT_ST_ACTIVE;
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			s_r <= '0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign o_current_count = s_r.count;
	assign o_count_captured_at_clear = s_r.captured;
	assign o_counter_state = s_r.state;
	assign o_begin_pulse = s_r.begin_p;
	assign o_finish_pulse = s_r.finish_p;

endmodule // dect_unit
`default_nettype wire

// ### shared/dect_pkg.sv
// package for the dual event counter timer
// assumes one 250 MHz clock and plain configuration ports
package dect_pkg;

	// ------------------------------------------------------------
	// sources and activation modes
	// ------------------------------------------------------------
	localparam int DECT_SRC_W = 5;
	localparam int DECT_NSRC  = 19;
	localparam logic [DECT_SRC_W-1:0] DECT_SRC_OFF        = 5'h00;
	localparam logic [DECT_SRC_W-1:0] DECT_SRC_USEC_TICK  = 5'h01;
	localparam logic [DECT_SRC_W-1:0] DECT_SRC_LINE0      = 5'h02;
	localparam logic [DECT_SRC_W-1:0] DECT_SRC_SOFT0      = 5'h06;
	localparam logic [DECT_SRC_W-1:0] DECT_SRC_C0_BEGIN   = 5'h0a;
	localparam logic [DECT_SRC_W-1:0] DECT_SRC_C1_BEGIN   = 5'h0b;
	localparam logic [DECT_SRC_W-1:0] DECT_SRC_C0_FINISH  = 5'h0c;
	localparam logic [DECT_SRC_W-1:0] DECT_SRC_C1_FINISH  = 5'h0d;
	localparam logic [DECT_SRC_W-1:0] DECT_SRC_LOGIC0     = 5'h0e;
	localparam logic [DECT_SRC_W-1:0] DECT_SRC_EXP_START  = 5'h10;
	localparam logic [DECT_SRC_W-1:0] DECT_SRC_EXP_END    = 5'h11;
	localparam logic [DECT_SRC_W-1:0] DECT_SRC_FRAME_PEND = 5'h12;
	// pulse sources ignore the activation mode
	localparam logic [DECT_NSRC-1:0] DECT_PULSE_MASK = 19'h33c02;

	typedef enum logic [2:0]
	{
		DECT_ACT_LEVEL_LOW  = 3'h0,
		DECT_ACT_LEVEL_HIGH = 3'h1,
		DECT_ACT_FALLING    = 3'h2,
		DECT_ACT_RISING     = 3'h3,
		DECT_ACT_ANY_EDGE   = 3'h4
	} dect_act_t;

	typedef enum logic [2:0]
	{
		DECT_ST_IDLE      = 3'h0,
		DECT_ST_TRIG_WAIT = 3'h1,
		DECT_ST_ACTIVE    = 3'h2,
		DECT_ST_COMPLETED = 3'h3,
		DECT_ST_OVERFLOW  = 3'h4
	} dect_state_t;

	// ------------------------------------------------------------
	// timing and fixed values
	// ------------------------------------------------------------
	localparam int DECT_CLK_PERIOD_NS = 4;
	localparam int DECT_TICK_NS       = 1000;
	localparam int DECT_TICK_CYCLES   = DECT_TICK_NS / DECT_CLK_PERIOD_NS;
	localparam int DECT_TICK_W        = 8;
	localparam logic [15:0] DECT_TEST_EVENT_TYPE_ID = 16'h4fff;
	localparam int DECT_TS_W = 64;

endpackage

// ### src/dect_top.sv
// dual event counter timer with test event readback
// assumes lines come from pins; all other inputs on i_mclk
//
// What this block does
// - two counters 0 and 1; settings and readback follow the index select
// - each counter increments on its chosen source from the shared list
// - increment source qualified by level low/high, falling, rising, any edge
// - start pulse when counted events reach the start delay count
// - end pulse when counted events reach the duration count
// - choosing a start trigger disables the clear source, and vice versa
// - counter starts when its chosen start trigger fires
// - start trigger qualified by the chosen activation mode
// - counter resets to zero and keeps counting when its chosen clear source fires
// - clear source qualified by the chosen activation mode
// - selected counter's present count is readable
// - count at each clear is captured into a readable field
// - selected counter's operating state is readable
// - test event type identifier reads as fixed 0x4fff
// - time of the test event is recorded and readable
`timescale 1ns/1ps
`default_nettype none
module dect_top
	import dect_pkg::*;
#(
	parameter int CNT_W = 32
)
(
	input  wire logic                  i_mclk,
	input  wire logic                  i_reset_n,
	input  wire logic                  i_counter_index_select,
	input  wire logic                  i_cfg_we,
	input  wire logic [DECT_SRC_W-1:0] i_increment_source_select,
	input  wire dect_act_t             i_increment_activation_mode,
	input  wire logic [CNT_W-1:0]      i_start_delay_count,
	input  wire logic [CNT_W-1:0]      i_end_duration_count,
	input  wire logic                  i_trig_we,
	input  wire logic [DECT_SRC_W-1:0] i_start_trigger_select,
	input  wire dect_act_t             i_start_trigger_activation_mode,
	input  wire logic                  i_clear_we,
	input  wire logic [DECT_SRC_W-1:0] i_clear_source_select,
	input  wire dect_act_t             i_clear_activation_mode,
	input  wire logic [3:0]            i_line,
	input  wire logic [3:0]            i_soft_output_line,
	input  wire logic [1:0]            i_custom_logic_output,
	input  wire logic                  i_exposure_start,
	input  wire logic                  i_exposure_end,
	input  wire logic                  i_frame_trigger_pending,
	input  wire logic                  i_test_event_generate,
	output logic [CNT_W-1:0]           o_current_count,
	output logic [CNT_W-1:0]           o_count_captured_at_clear,
	output dect_state_t                o_counter_state,
	output logic [1:0]                 o_counter_begin_pulse,
	output logic [1:0]                 o_counter_finish_pulse,
	output logic [15:0]                o_test_event_type_id,
	output logic [DECT_TS_W-1:0]       o_test_event_time_stamp
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed
	{
		// microsecond tick divider
		logic [DECT_TICK_W-1:0] tick_cnt;
		logic                   tick;
		// line synchroniser, two flops
		logic [3:0]             line_m;
		logic [3:0]             line_s;
		// edge history, free-running time and the test event time
		logic [DECT_NSRC-1:0]   src_prev;
		logic [DECT_TS_W-1:0]   now;
		logic [DECT_TS_W-1:0]   test_ts;
		// registered readback of the selected counter and the type id
		logic [CNT_W-1:0]       rd_count;
		logic [CNT_W-1:0]       rd_captured;
		dect_state_t            rd_state;
		logic [15:0]            type_id;
	} dect_top_t;

	dect_top_t s_r;
	dect_top_t s_nxt;

	// last value of the tick divider
	localparam logic [DECT_TICK_W-1:0] TICK_LAST =
		DECT_TICK_W'(DECT_TICK_CYCLES - 1);

	logic [DECT_NSRC-1:0] src;
	logic [CNT_W-1:0]     u_count [2];
	logic [CNT_W-1:0]     u_capt  [2];
	dect_state_t          u_state [2];
	logic [1:0]           u_begin;
	logic [1:0]           u_finish;

	logic [1:0]           cfg_we_u;
	logic [1:0]           trig_we_u;
	logic [1:0]           clear_we_u;

	// ------------------------------------------------------------
	// shared source vector
	// ------------------------------------------------------------
	always_comb
	begin
		src = '0;
		src[DECT_SRC_USEC_TICK] = s_r.tick;
		// lines reach the counters only through the synchroniser
		src[DECT_SRC_LINE0 +: 4] = s_r.line_s;
		src[DECT_SRC_SOFT0 +: 4] = i_soft_output_line;
		// counter pulses are selectable by both counters
		src[DECT_SRC_C0_BEGIN] = u_begin[0];
		src[DECT_SRC_C1_BEGIN] = u_begin[1];
		src[DECT_SRC_C0_FINISH] = u_finish[0];
		src[DECT_SRC_C1_FINISH] = u_finish[1];
		src[DECT_SRC_LOGIC0 +: 2] = i_custom_logic_output;
		src[DECT_SRC_EXP_START] = i_exposure_start;
		src[DECT_SRC_EXP_END] = i_exposure_end;
		src[DECT_SRC_FRAME_PEND] = i_frame_trigger_pending;
	end

	// ------------------------------------------------------------
	// write steering
	// ------------------------------------------------------------
	// a strobe reaches only the counter that the index names;
	// the other counter keeps its settings and its count
	always_comb
	begin
		cfg_we_u = 2'h0;
		trig_we_u = 2'h0;
		clear_we_u = 2'h0;
		cfg_we_u[i_counter_index_select] = i_cfg_we;
		trig_we_u[i_counter_index_select] = i_trig_we;
		clear_we_u[i_counter_index_select] = i_clear_we;
	end

	// ------------------------------------------------------------
	// counters
	// ------------------------------------------------------------
	// both counters share one source vector and its history
	for (genvar g = 0; g < 2; g++)
	begin : g_unit
		dect_unit #(
			.CNT_W (CNT_W)
		) u_unit (
			.i_mclk                          (i_mclk),
			.i_reset_n                       (i_reset_n),
			.i_cfg_we                        (cfg_we_u[g]),
			.i_increment_source_select       (i_increment_source_select),
			.i_increment_activation_mode     (i_increment_activation_mode),
			.i_start_delay_count             (i_start_delay_count),
			.i_end_duration_count            (i_end_duration_count),
			.i_trig_we                       (trig_we_u[g]),
			.i_start_trigger_select          (i_start_trigger_select),
			.i_start_trigger_activation_mode (i_start_trigger_activation_mode),
			.i_clear_we                      (clear_we_u[g]),
			.i_clear_source_select           (i_clear_source_select),
			.i_clear_activation_mode         (i_clear_activation_mode),
			.i_src                           (src),
			.i_src_prev                      (s_r.src_prev),
			.o_current_count                 (u_count[g]),
			.o_count_captured_at_clear       (u_capt[g]),
			.o_counter_state                 (u_state[g]),
			.o_begin_pulse                   (u_begin[g]),
			.o_finish_pulse                  (u_finish[g])
		);
	end

	// ------------------------------------------------------------
	// tick, sync, timestamp, readback
	// ------------------------------------------------------------
	always_comb
	begin
		s_nxt = s_r;
		// one-cycle tick every microsecond of clocks
		s_nxt.tick = (s_r.tick_cnt == TICK_LAST);
		s_nxt.tick_cnt = s_nxt.tick ? '0 : s_r.tick_cnt + 1'b1;

		// pins cross into the clock domain here
		s_nxt.line_m = i_line;
		s_nxt.line_s = s_r.line_m;

		// history for the edge qualifiers
		s_nxt.src_prev = src;

		// free-running time, captured on a test event
		s_nxt.now = s_r.now + 1'b1;
		if (i_test_event_generate)
			s_nxt.test_ts = s_r.now;

		// readback registered so every output is a flop
		s_nxt.rd_count = u_count[i_counter_index_select];
		s_nxt.rd_captured = u_capt[i_counter_index_select];
		s_nxt.rd_state = u_state[i_counter_index_select];
		s_nxt.type_id = DECT_TEST_EVENT_TYPE_ID;
	end

	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			s_r <= '0;
			// the type id reads correctly even in reset
			s_r.type_id <= DECT_TEST_EVENT_TYPE_ID;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_current_count = s_r.rd_count;
	assign o_count_captured_at_clear = s_r.rd_captured;
	assign o_counter_state = s_r.rd_state;
	assign o_counter_begin_pulse = u_begin;
	assign o_counter_finish_pulse = u_finish;
	assign o_test_event_type_id = s_r.type_id;
	assign o_test_event_time_stamp = s_r.test_ts;

endmodule // dect_top
`default_nettype wire

// ### testbench/dect_top_chk.sv
// assertion checker for the dual event counter timer top
// assumes the top ports only; bound to every dect_top instance
`timescale 1ns/1ps
`default_nettype none
module dect_top_chk
	import dect_pkg::*;
#(
	parameter int CNT_W = 32
)
(
	input wire logic                  i_mclk,
	input wire logic                  i_reset_n,
	input wire logic                  i_counter_index_select,
	input wire logic                  i_cfg_we,
	input wire logic                  i_trig_we,
	input wire logic                  i_clear_we,
	input wire logic [DECT_SRC_W-1:0] i_start_trigger_select,
	input wire logic [DECT_SRC_W-1:0] i_clear_source_select,
	input wire logic                  i_test_event_generate,
	input wire logic [CNT_W-1:0]      o_current_count,
	input wire dect_state_t           o_counter_state,
	input wire logic [1:0]            o_counter_begin_pulse,
	input wire logic [1:0]            o_counter_finish_pulse,
	input wire logic [15:0]           o_test_event_type_id,
	input wire logic [DECT_TS_W-1:0]  o_test_event_time_stamp
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);

	// ------------------------------------------------------------
	// write steps seen at the readback two edges later
	// ------------------------------------------------------------
	sequence s_idx_hold;
		$stable(i_counter_index_select) [*2];
	endsequence
	sequence s_cfg_wr;
		i_cfg_we && !i_trig_we && !i_clear_we ##1 s_idx_hold;
	endsequence
	sequence s_trig_wr;
		i_trig_we && (i_start_trigger_select != 5'h00) ##1 s_idx_hold;
	endsequence
	sequence s_clr_wr;
		i_clear_we && !i_trig_we && (i_clear_source_select != 5'h00)
			##1 s_idx_hold;
	endsequence

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	AST_CFG_RESTART: assert property (s_cfg_wr |-> o_current_count == '0
		&& o_counter_state inside {DECT_ST_TRIG_WAIT, DECT_ST_ACTIVE})
		else $error("config write did not restart the counter");
	AST_TRIG_WAIT: assert property (s_trig_wr |->
		o_counter_state == DECT_ST_TRIG_WAIT)
		else $error("trigger write did not enter trigger wait");
	AST_CLR_ACTIVE: assert property (s_clr_wr |->
		o_counter_state == DECT_ST_ACTIVE && o_current_count == '0)
		else $error("clear write did not leave counter active at zero");
	AST_IDLE_ZERO: assert property (o_counter_state == DECT_ST_IDLE
		|-> o_current_count == '0)
		else $error("idle counter holds a nonzero count");
	AST_WAIT_ZERO: assert property (o_counter_state == DECT_ST_TRIG_WAIT
		|-> o_current_count == '0)
		else $error("counter moved while waiting for trigger");
	AST_TYPE_ID: assert property (o_test_event_type_id == 16'h4fff)
		else $error("test event type id wrong");
	AST_TS_HOLD: assert property (!i_test_event_generate |=>
		$stable(o_test_event_time_stamp))
		else $error("time stamp changed without a test event");
	AST_TS_STEP: assert property (i_test_event_generate ##1
		i_test_event_generate |=> o_test_event_time_stamp ==
		$past(o_test_event_time_stamp) + 64'h1)
		else $error("adjacent test events not one cycle apart");
	AST_BEGIN_ONE: assert property (|o_counter_begin_pulse |=>
		(o_counter_begin_pulse & $past(o_counter_begin_pulse)) == 2'h0)
		else $error("begin pulse longer than one cycle");
	AST_FINISH_ONE: assert property (|o_counter_finish_pulse |=>
		(o_counter_finish_pulse & $past(o_counter_finish_pulse)) == 2'h0)
		else $error("finish pulse longer than one cycle");
endmodule // dect_top_chk

bind dect_top dect_top_chk #(.CNT_W(CNT_W)) i_chk (
	.i_mclk(i_mclk), .i_reset_n(i_reset_n),
	.i_counter_index_select(i_counter_index_select),
	.i_cfg_we(i_cfg_we), .i_trig_we(i_trig_we), .i_clear_we(i_clear_we),
	.i_start_trigger_select(i_start_trigger_select),
	.i_clear_source_select(i_clear_source_select),
	.i_test_event_generate(i_test_event_generate),
	.o_current_count(o_current_count), .o_counter_state(o_counter_state),
	.o_counter_begin_pulse(o_counter_begin_pulse),
	.o_counter_finish_pulse(o_counter_finish_pulse),
	.o_test_event_type_id(o_test_event_type_id),
	.o_test_event_time_stamp(o_test_event_time_stamp));
`default_nettype wire

// ### testbench/dect_top_tb.sv
// self-checking testbench for the dual event counter timer
// assumes the bound checker; the bench drives every port itself
`timescale 1ns/1ps
`default_nettype none
module dect_top_tb
	import dect_pkg::*;
;
	localparam int CW = 4;
	localparam logic [7:0] PAT = 8'h34;
	typedef struct packed
	{
		logic [4:0] src;
		dect_act_t  mode;
		logic       idle;
		logic [3:0] exp;
		logic       idx;
	} dect_row_t;
	dect_row_t rows [6] = '{
		'{DECT_SRC_SOFT0, DECT_ACT_LEVEL_HIGH, 1'b0, 4'h3, 1'b0},
		'{DECT_SRC_SOFT0, DECT_ACT_LEVEL_LOW, 1'b1, 4'h5, 1'b1},
		'{DECT_SRC_LINE0, DECT_ACT_RISING, 1'b0, 4'h2, 1'b0},
		'{DECT_SRC_LOGIC0, DECT_ACT_FALLING, 1'b0, 4'h2, 1'b1},
		'{DECT_SRC_FRAME_PEND, DECT_ACT_ANY_EDGE, 1'b0, 4'h4, 1'b0},
		'{DECT_SRC_OFF, DECT_ACT_ANY_EDGE, 1'b0, 4'h0, 1'b1}};
	logic          i_mclk = 1'b0;
	logic          i_reset_n = 1'b0;
	logic          i_idx = 1'b0;
	logic          i_cfg_we = 1'b0;
	logic          i_trig_we = 1'b0;
	logic          i_clear_we = 1'b0;
	logic [4:0]    i_sel = 5'h00;
	dect_act_t     i_mode = DECT_ACT_LEVEL_LOW;
	logic [CW-1:0] i_dly = '0;
	logic [CW-1:0] i_dur = '0;
	logic [3:0]    i_line = 4'h0;
	logic [3:0]    i_soft = 4'h0;
	logic [1:0]    i_logic = 2'h0;
	logic          i_exp_start = 1'b0;
	logic          i_exp_end = 1'b0;
	logic          i_frame = 1'b0;
	logic          i_gen = 1'b0;
	logic [CW-1:0] o_count;
	logic [CW-1:0] o_capt;
	dect_state_t   o_state;
	logic [1:0]    o_begin;
	logic [1:0]    o_finish;
	logic [15:0]   o_id;
	logic [63:0]   o_ts;
	logic [63:0]   t1;
	int            errors = 0;
	int            cmp_count = 0;
	int            cyc = 0;
	int            bcnt [2] = '{0, 0};
	int            fcnt [2] = '{0, 0};

	dect_top #(.CNT_W(CW)) i_dut (
		.i_mclk(i_mclk), .i_reset_n(i_reset_n),
		.i_counter_index_select(i_idx), .i_cfg_we(i_cfg_we),
		.i_increment_source_select(i_sel), .i_increment_activation_mode(i_mode),
		.i_start_delay_count(i_dly), .i_end_duration_count(i_dur),
		.i_trig_we(i_trig_we), .i_start_trigger_select(i_sel),
		.i_start_trigger_activation_mode(i_mode), .i_clear_we(i_clear_we),
		.i_clear_source_select(i_sel), .i_clear_activation_mode(i_mode),
		.i_line(i_line), .i_soft_output_line(i_soft),
		.i_custom_logic_output(i_logic), .i_exposure_start(i_exp_start),
		.i_exposure_end(i_exp_end), .i_frame_trigger_pending(i_frame),
		.i_test_event_generate(i_gen), .o_current_count(o_count),
		.o_count_captured_at_clear(o_capt), .o_counter_state(o_state),
		.o_counter_begin_pulse(o_begin), .o_counter_finish_pulse(o_finish),
		.o_test_event_type_id(o_id), .o_test_event_time_stamp(o_ts));

	// ------------------------------------------------------------
	// clock, pulse counting, hang guard
	// ------------------------------------------------------------
	always #2 i_mclk = ~i_mclk;
	always @(negedge i_mclk)
	begin
		bcnt[0] += int'(o_begin[0]);
		bcnt[1] += int'(o_begin[1]);
		fcnt[0] += int'(o_finish[0]);
	end
	always @(posedge i_mclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			errors++;
			stop_test();
		end
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic step(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	// k: 0 settings, 1 start trigger, 2 clear source
	task automatic wr(input int k, input logic x, input logic [4:0] s,
		input dect_act_t m, input logic [CW-1:0] d, input logic [CW-1:0] u);
		i_idx = x;
		i_sel = s;
		i_mode = m;
		i_dly = d;
		i_dur = u;
		{i_cfg_we, i_trig_we, i_clear_we} = {k == 0, k == 1, k == 2};
		step(1);
		{i_cfg_we, i_trig_we, i_clear_we} = 3'h0;
		step(1);
	endtask
	task automatic lvl(input logic v);
		i_line[0] = v;
		i_soft[0] = v;
		i_logic[0] = v;
		i_frame = v;
	endtask
	task automatic pulse(ref logic s, input int n);
		repeat (n)
		begin
			s = 1'b1;
			step(1);
			s = 1'b0;
			step(2);
		end
	endtask
	task automatic stop_test();
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial
	begin
		step(20);
		i_reset_n = 1'b1;
		step(1);
		foreach (rows[r])
		begin
			lvl(rows[r].idle);
			wr(0, rows[r].idx, rows[r].src, rows[r].mode, '0, '0);
			step(2);
			for (int b = 0; b < 8; b++)
			begin
				lvl(PAT[b]);
				step(1);
			end
			lvl(rows[r].idle);
			step(6);
			chk(o_count, rows[r].exp);
			chk(o_state, DECT_ST_ACTIVE);
		end
		// counter 1 counts the finish pulses of counter 0
		wr(0, 1'b1, DECT_SRC_C0_FINISH, DECT_ACT_RISING, 4'h1, 4'h5);
		wr(0, 1'b0, DECT_SRC_EXP_START, DECT_ACT_RISING, 4'h2, 4'h3);
		bcnt = '{0, 0};
		fcnt = '{0, 0};
		pulse(i_exp_start, 4);
		step(3);
		chk(o_count, 64'h3);
		chk(o_state, DECT_ST_COMPLETED);
		chk(bcnt[0], 64'h1);
		chk(fcnt[0], 64'h1);
		chk(bcnt[1], 64'h1);
		i_idx = 1'b1;
		step(2);
		chk(o_count, 64'h1);
		wr(0, 1'b0, DECT_SRC_EXP_END, DECT_ACT_LEVEL_HIGH, '0, '0);
		wr(1, 1'b0, 5'h07, DECT_ACT_RISING, '0, '0);
		step(1);
		chk(o_state, DECT_ST_TRIG_WAIT);
		pulse(i_exp_end, 2);
		chk(o_count, 64'h0);
		i_soft[1] = 1'b1;
		step(3);
		chk(o_state, DECT_ST_ACTIVE);
		pulse(i_exp_end, 2);
		step(2);
		chk(o_count, 64'h2);
		i_soft[2] = 1'b1;
		wr(2, 1'b0, 5'h08, DECT_ACT_FALLING, '0, '0);
		step(1);
		chk(o_state, DECT_ST_ACTIVE);
		pulse(i_exp_end, 3);
		i_soft[2] = 1'b0;
		step(4);
		chk(o_capt, 64'h3);
		chk(o_count, 64'h0);
		chk(o_state, DECT_ST_ACTIVE);
		// trigger write must switch the clear source off
		wr(1, 1'b0, 5'h07, DECT_ACT_RISING, '0, '0);
		i_soft[2] = 1'b1;
		step(2);
		i_soft[2] = 1'b0;
		step(4);
		chk(o_state, DECT_ST_TRIG_WAIT);
		wr(0, 1'b1, DECT_SRC_FRAME_PEND, DECT_ACT_LEVEL_HIGH, '0, '0);
		i_frame = 1'b1;
		step(20);
		i_frame = 1'b0;
		step(2);
		chk(o_state, DECT_ST_OVERFLOW);
		chk(o_count, 64'hf);
		// 500 counted edges hold exactly two microsecond ticks
		wr(0, 1'b1, DECT_SRC_USEC_TICK, DECT_ACT_LEVEL_HIGH, '0, '0);
		step(500);
		chk(o_count, 64'h2);
		i_gen = 1'b1;
		step(2);
		i_gen = 1'b0;
		step(2);
		t1 = o_ts;
		step(6);
		i_gen = 1'b1;
		step(1);
		i_gen = 1'b0;
		step(2);
		chk(o_ts - t1, 64'h9);
		i_reset_n = 1'b0;
		step(1);
		chk(o_id, 64'h4fff);
		chk(o_ts, 64'h0);
		i_reset_n = 1'b1;
		step(2);
		chk(o_state, DECT_ST_IDLE);
		chk(o_count, 64'h0);
		stop_test();
	end
endmodule // dect_top_tb
`default_nettype wire
